// *** core/vpw_frame_transmitter.sv ***
// Purpose: vpw bus message frame transmitter with Avalon-MM registers
// Assumes: 25 MHz clock, bus pins synchronous to it
// Notes:   symbols are timed from the filtered echo of the bus
`timescale 1ns/1ns
`default_nettype none
module vpw_frame_transmitter
    import vpw_pkg::*;
#(
    parameter int P_TV3_CYC = TV3_NOM_CYC,
    parameter int P_TV4_LO_CYC = TV4_LO_CYC,
    parameter int P_TV4_NOM_CYC = TV4_NOM_CYC,
    parameter int P_TV6_CYC = TV6_NOM_CYC
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // avalon-mm slave
    input wire logic [2:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // bus transceiver
    input wire logic i_bus_rx_line,
    output logic o_bus_tx_line,
    // interrupt request, level
    output logic o_lost_arb_irq
);

    localparam int RW = $clog2(P_TV6_CYC + 2);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (P_TV4_LO_CYC >= P_TV4_NOM_CYC || P_TV6_CYC < P_TV4_NOM_CYC ||
        P_TV3_CYC <= TV2_NOM_CYC) begin : g_chk_tv
        $error("symbol times out of order");
    end
    if (TV1_NOM_CYC <= LOOP_DELAY_MAX_CYC + FILT_LAT_CYC) begin : g_chk_dly
        $error("loop delay leaves no room for a short symbol");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        vpw_tx_state_type st;
        logic tx_line;
        vpw_ctrl_type ctrl;
        logic [7:0] tx_byte_reg;
        logic [31:0] message_filter_bits;
        logic tx_ready_flag;
        logic tx_lost_arb_flag;
        logic invalid_bit_flag;
        logic rx_full_flag;
        logic [7:0] rx_byte_reg;
        logic pend;
        logic pend_last;
        logic armed;
        logic last;
        logic sof;
        logic crc_phase;
        logic first_byte;
        logic [7:0] shreg;
        logic [7:0] rxsh;
        logic [7:0] crc;
        logic [2:0] bit_cnt;
        logic [4:0] filt_idx;
        logic [10:0] echo_cnt;
        logic [RW-1:0] run_cnt;
        logic rx_prev;
        logic sof_phase;
        logic suppress;
        logic ack;
        logic [31:0] rdata;
    } vpw_state_type;

    vpw_state_type s;
    vpw_state_type next_s;
    logic rx_f;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic int dly_cyc(input logic [4:0] dly);
        return int'(dly) * CYC_PER_US;
    endfunction

    function automatic int hold_target(input logic sof, input logic bitv,
                                       input logic lvl, input logic [4:0] dly);
        int nom;
        if (sof) begin
            nom = P_TV3_CYC;
        end else if (bitv ^ lvl) begin
            nom = TV2_NOM_CYC;
        end else begin
            nom = TV1_NOM_CYC;
        end
        return nom - dly_cyc(dly) - FILT_LAT_CYC;
    endfunction

    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
        return {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC_POLY : 8'h00);
    endfunction

    // ------------------------------------------------------------
    // input filter
    // ------------------------------------------------------------
    vpw_rx_filter #(
        .P_LEN(FILT_LAT_CYC)
    ) u_filter (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_line(i_bus_rx_line),
        .i_invert(s.ctrl.rx_invert),
        .o_level(rx_f)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic rx_edge;
        logic early;
        logic quiet4;
        logic quiet6;
        logic xfer;
        logic lost;
        logic inval;
        logic sym_done;
        logic [7:0] fbyte;
        logic [4:0] idx;
        logic [7:0] crc_nx;
        logic taken;
        rx_edge = rx_f != s.rx_prev;
        early = 1'b0;
        quiet4 = 1'b0;
        quiet6 = 1'b0;
        xfer = 1'b0;
        lost = 1'b0;
        inval = 1'b0;
        sym_done = 1'b0;
        fbyte = 8'h00;
        idx = 5'h00;
        crc_nx = 8'h00;
        taken = (i_avs_read | i_avs_write) & s.ack;
        next_s = s;

        // --------------------------------------------------------
        // bus slave: one wait cycle, then taken
        // --------------------------------------------------------
        next_s.ack = (i_avs_read | i_avs_write) & ~s.ack;
        if (i_avs_read & ~s.ack) begin
            unique case (i_avs_address)
                REG_CTRL: next_s.rdata = {25'h0, s.ctrl};
                REG_TX_BYTE_REG: next_s.rdata = {24'h0, s.tx_byte_reg};
                REG_STATUS: next_s.rdata = {27'h0, s.st != TX_IDLE, s.rx_full_flag,
                                            s.invalid_bit_flag, s.tx_lost_arb_flag,
                                            s.tx_ready_flag};
                REG_RX_BYTE_REG: next_s.rdata = {24'h0, s.rx_byte_reg};
                REG_FILTER: next_s.rdata = s.message_filter_bits;
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end
        if (!s.pend && !s.tx_ready_flag) begin
            next_s.tx_ready_flag = 1'b1;
        end
        if (taken && i_avs_read && i_avs_address == REG_RX_BYTE_REG) begin
            next_s.rx_full_flag = 1'b0;
        end
        if (taken && i_avs_write) begin
            unique case (i_avs_address)
                REG_CTRL: begin
                    if (i_avs_byteenable[0]) begin
                        next_s.ctrl = i_avs_writedata[CTRL_MASK_BIT:CTRL_DLY_LSB];
                    end
                end
                REG_TX_BYTE_REG: begin
                    if (i_avs_byteenable[0]) begin
                        next_s.tx_byte_reg = i_avs_writedata[7:0];
                    end
                end
                REG_STATUS: begin
                    if (i_avs_byteenable[0] && i_avs_writedata[STAT_TLA_BIT]) begin
                        next_s.tx_lost_arb_flag = 1'b0;
                    end
                    if (i_avs_byteenable[0] && i_avs_writedata[STAT_IBD_BIT]) begin
                        next_s.invalid_bit_flag = 1'b0;
                    end
                end
                REG_FILTER: begin
                    for (int b = 0; b < 4; b++) begin
                        if (i_avs_byteenable[b]) begin
                            next_s.message_filter_bits[8*b +: 8] = i_avs_writedata[8*b +: 8];
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // --------------------------------------------------------
        // bus observation from the filtered decoder input
        // --------------------------------------------------------
        next_s.rx_prev = rx_f;
        if (rx_edge) begin
            next_s.run_cnt = '0;
            if (s.run_cnt <= RW'(TV1_LO_CYC)) begin
                inval = 1'b1;
                next_s.invalid_bit_flag = 1'b1;
                next_s.suppress = 1'b1;
            end
            next_s.sof_phase = rx_f && s.run_cnt > RW'(P_TV4_LO_CYC);
        end else if (s.run_cnt != '1) begin
            next_s.run_cnt = s.run_cnt + 1'b1;
        end
        if (!rx_f && s.run_cnt > RW'(P_TV4_LO_CYC)) begin
            next_s.suppress = 1'b0;
        end
        quiet4 = !rx_f && s.run_cnt >= RW'(P_TV4_NOM_CYC);
        quiet6 = !rx_f && s.run_cnt >= RW'(P_TV6_CYC);
        // another node opened a frame early; join while still in time
        early = rx_f && s.sof_phase && !s.suppress &&
                s.run_cnt <= RW'(SOF_SYNC_CYC);

        // --------------------------------------------------------
        // transmit sequencer
        // --------------------------------------------------------
        unique case (s.st)
            TX_IDLE: begin
                next_s.tx_line = 1'b0;
                xfer = s.pend && !s.armed && (quiet4 || early);
                if (xfer) begin
                    next_s.shreg = s.tx_byte_reg;
                    next_s.last = s.pend_last;
                    next_s.pend = 1'b0;
                    next_s.tx_ready_flag = 1'b1;
                    next_s.armed = 1'b1;
                end
                if ((s.armed || xfer) && (quiet6 || early)) begin
                    next_s.st = TX_ECHO;
                    next_s.tx_line = 1'b1;
                    next_s.sof = 1'b1;
                    next_s.armed = 1'b0;
                    next_s.crc = CRC_INIT;
                    next_s.crc_phase = 1'b0;
                    next_s.first_byte = 1'b1;
                    next_s.bit_cnt = 3'h0;
                    next_s.echo_cnt = '0;
                end
            end
            TX_ECHO: begin
                if (s.echo_cnt != '1) begin
                    next_s.echo_cnt = s.echo_cnt + 1'b1;
                end
                if (rx_f == s.tx_line) begin
                    next_s.st = TX_HOLD;
                end else if (!s.tx_line && int'(s.echo_cnt) >
                             dly_cyc(s.ctrl.loop_delay_setting) + FILT_LAT_CYC + TV1_LO_CYC) begin
                    lost = 1'b1;
                end
            end
            TX_HOLD: begin
                if (rx_f != s.tx_line) begin
                    lost = 1'b1;
                end else if (s.run_cnt >= RW'(hold_target(s.sof, s.shreg[7], s.tx_line,
                                                           s.ctrl.loop_delay_setting))) begin
                    sym_done = 1'b1;
                end
            end
            TX_EOD: begin
                if (!rx_f) begin
                    next_s.st = TX_IDLE;
                end
            end
        endcase

        if (sym_done) begin
            next_s.st = TX_ECHO;
            next_s.echo_cnt = '0;
            next_s.tx_line = ~s.tx_line;
            if (s.sof) begin
                next_s.sof = 1'b0;
            end else begin
                crc_nx = crc_step(s.crc, s.shreg[7]);
                if (!s.crc_phase) begin
                    next_s.crc = crc_nx;
                end
                next_s.shreg = {s.shreg[6:0], 1'b0};
                next_s.rxsh = {s.rxsh[6:0], s.shreg[7]};
                next_s.bit_cnt = s.bit_cnt + 3'h1;
                if (s.bit_cnt == 3'h7) begin
                    fbyte = {s.rxsh[6:0], s.shreg[7]};
                    idx = s.first_byte ? fbyte[7:3] : s.filt_idx;
                    next_s.filt_idx = idx;
                    next_s.first_byte = 1'b0;
                    if (s.message_filter_bits[idx] && !s.suppress) begin
                        next_s.rx_byte_reg = fbyte;
                        next_s.rx_full_flag = 1'b1;
                    end
                    if (s.crc_phase) begin
                        next_s.st = TX_EOD;
                    end else if (s.last) begin
                        next_s.crc_phase = 1'b1;
                        next_s.shreg = ~crc_nx;
                    end else if (s.pend) begin
                        next_s.shreg = s.tx_byte_reg;
                        next_s.last = s.pend_last;
                        next_s.pend = 1'b0;
                        next_s.tx_ready_flag = 1'b1;
                    end else begin
                        // no byte queued in time: end the frame without crc
                        next_s.st = TX_IDLE;
                    end
                end
            end
        end

        if (lost || (inval && s.st != TX_IDLE)) begin
            next_s.st = TX_IDLE;
            next_s.tx_line = 1'b0;
            next_s.sof = 1'b0;
            next_s.crc_phase = 1'b0;
            // the frame is dropped; data register is kept for a resend
            if (!s.last) begin
                next_s.pend = 1'b0;
            end
        end
        if (lost) begin
            next_s.tx_lost_arb_flag = 1'b1;
        end

        // opcode write last: a new request outranks a same-cycle transfer
        if (taken && i_avs_write && i_avs_address == REG_TX_OPCODE_REG && i_avs_byteenable[0]) begin
            next_s.tx_ready_flag = 1'b0;
            if (i_avs_writedata[2:0] == OP_MSG || i_avs_writedata[2:0] == OP_MSG_LAST) begin
                next_s.pend = 1'b1;
                next_s.pend_last = i_avs_writedata[2:0] == OP_MSG_LAST;
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s <= '0;
            s.st <= TX_IDLE;
            s.ctrl <= {1'b0, 1'b0, DLY_RST};
            s.message_filter_bits <= FILTER_RST;
            s.tx_ready_flag <= 1'b1;
            s.crc <= CRC_INIT;
            s.run_cnt <= '1;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_avs_readdata = s.rdata;
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~s.ack;
    assign o_bus_tx_line = s.tx_line;
    assign o_lost_arb_irq = s.tx_lost_arb_flag & s.ctrl.lost_arb_irq_mask;

endmodule
`default_nettype wire

// *** core/vpw_rx_filter.sv ***
// Purpose: polarity select and digital glitch filter on the bus input
// Assumes: input synchronous to i_sys_clk
// Notes:   level flips after P_LEN equal samples; latency is P_LEN cycles
`timescale 1ns/1ns
`default_nettype none
module vpw_rx_filter
    import vpw_pkg::*;
#(
    parameter int P_LEN = FILT_LAT_CYC
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // line
    input wire logic i_line,
    input wire logic i_invert,
    // filtered level, 1 = active
    output logic o_level
);

    localparam int W = $clog2(P_LEN + 1);

    typedef struct packed {
        logic level;
        logic [W-1:0] cnt;
    } vpw_filt_type;

    vpw_filt_type s;
    vpw_filt_type next_s;

    if (P_LEN < 1) begin : g_chk
        $error("filter length must be at least one");
    end

    always_comb begin
        next_s = s;
        if ((i_line ^ i_invert) == s.level) begin
            next_s.cnt = '0;
        end else if (s.cnt == W'(P_LEN - 1)) begin
            next_s.level = ~s.level;
            next_s.cnt = '0;
        end else begin
            next_s.cnt = s.cnt + 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_level = s.level;

endmodule
`default_nettype wire

// *** dv/test_vpw_frame_transmitter.sv ***
// Purpose: self-checking bench of the vpw frame transmitter
// Assumes: loop delay setting 2, shortened frame timing
// Notes:   bit values are decoded from measured symbol lengths between output toggles
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin errors++; \
    $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module test_vpw_frame_transmitter
    import vpw_pkg::*;
;
    logic clk, rst_n, rd, wr, other, txq;
    logic [2:0] adr;
    logic [3:0] be;
    logic [31:0] wdat, rdat, o_rdat;
    logic o_wait, rx, tx, irq;
    int errors = 0, comparisons = 0, cyc = 0;
    int tog[$];
    vpw_frame_transmitter #(.P_TV3_CYC(3300), .P_TV4_LO_CYC(3400), .P_TV4_NOM_CYC(3500),
        .P_TV6_CYC(3600)) u_vpw_frame_transmitter (.i_sys_clk(clk), .i_resetn(rst_n),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(be),
        .i_avs_writedata(wdat), .o_avs_readdata(o_rdat), .o_avs_waitrequest(o_wait),
        .i_bus_rx_line(rx), .o_bus_tx_line(tx), .o_lost_arb_irq(irq));
    vpw_bus_model #(.P_DLY(50)) u_vpw_bus_model (.i_sys_clk(clk), .i_tx(tx), .i_other_active(other), .o_rx(rx));
    // ------------------------------------------------------------
    // clock, toggle log and hang limit
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (tx !== txq) tog.push_back(cyc);
        txq = tx;
        if (cyc == 90000) begin
            errors++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // wait request is sampled at the rising edge that takes the request
    task automatic avl(input logic r, input logic [2:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wdat <= d;
        rd <= r;
        wr <= !r;
        do @(posedge clk); while (o_wait !== 1'b0);
        rdat = o_rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wait_tog(input int k);
        while (tog.size() < k) @(posedge clk);
    endtask
    function automatic logic [7:0] crc8(input logic [7:0] b);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 7; i >= 0; i--) c = (c[7] ^ b[i]) ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
        return ~c;
    endfunction
    task automatic t_reset_values();
        logic [31:0] exp[8] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 8; i++) begin
            avl(1'b1, 3'(i), 32'h0);
            `CHK("reset value", exp[i], rdat)
        end
        avl(1'b0, REG_CTRL, 32'h0000_0042);
        // lane 0 disabled: the control byte must not move
        be <= 4'hE;
        avl(1'b0, REG_CTRL, 32'h0);
        be <= 4'hF;
        avl(1'b1, REG_CTRL, 32'h0);
        `CHK("control", 32'h0000_0042, rdat)
        avl(1'b0, REG_FILTER, 32'h0000_0400);
        $display("test reset_values done");
    endtask
    task automatic t_queue_and_lose();
        int t0;
        other <= 1'b1;
        repeat (3000) @(posedge clk);
        avl(1'b0, REG_TX_BYTE_REG, 32'h0000_0055);
        avl(1'b0, REG_TX_OPCODE_REG, {29'h0, OP_MSG});
        avl(1'b1, REG_STATUS, 32'h0);
        `CHK("ready while queued", 1'b0, rdat[STAT_RDY_BIT])
        `CHK("late join", 0, tog.size())
        other <= 1'b0;
        t0 = cyc;
        wait_tog(1);
        `CHK("ifs wait", 1'b1, (tog[0] - t0) inside {[3700:3900]})
        avl(1'b1, REG_STATUS, 32'h0);
        `CHK("ready after eof", 1'b1, rdat[STAT_RDY_BIT])
        wait_tog(2);
        repeat (300) @(posedge clk);
        other <= 1'b1;
        for (int n = 0; n < 1000 && irq !== 1'b1; n++) @(posedge clk);
        `CHK("lost irq", 1'b1, irq)
        `CHK("released", 1'b0, tx)
        other <= 1'b0;
        repeat (4000) @(posedge clk);
        `CHK("no retry", 2, tog.size())
        avl(1'b1, REG_STATUS, 32'h0);
        `CHK("lost flag", 1'b1, rdat[STAT_TLA_BIT])
        `CHK("invalid bit", 1'b1, rdat[STAT_IBD_BIT])
        avl(1'b0, REG_STATUS, 32'h0000_0002);
        @(negedge clk);
        `CHK("irq cleared", 1'b0, irq)
        $display("test queue_and_lose done");
    endtask
    task automatic t_retry_frame();
        int k, d;
        logic [15:0] bits;
        k = tog.size();
        avl(1'b0, REG_TX_OPCODE_REG, {29'h0, OP_MSG_LAST});
        repeat (3) @(posedge clk);
        `CHK("idle start", k + 1, tog.size())
        wait_tog(k + 18);
        `CHK("sof length", 1'b1, (tog[k + 1] - tog[k]) inside {[3260:3340]})
        for (int i = 1; i <= 16; i++) begin
            d = tog[k + i + 1] - tog[k + i];
            bits = {bits[14:0], (i % 2 == 1) ? (d > 2400) : (d < 2400)};
            `CHK("bit length", 1'b1, d inside {[1560:1640], [3160:3240]})
        end
        `CHK("data byte", 8'h55, bits[15:8])
        `CHK("crc byte", crc8(8'h55), bits[7:0])
        repeat (300) @(posedge clk);
        `CHK("eod passive", 1'b0, tx)
        avl(1'b1, REG_STATUS, 32'h0);
        `CHK("rx full", 1'b1, rdat[STAT_RX_FULL_FLAG_BIT])
        avl(1'b1, REG_RX_BYTE_REG, 32'h0);
        `CHK("loopback", {24'h0, crc8(8'h55)}, rdat)
        $display("test retry_frame done");
    endtask
    initial begin
        rst_n = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        other = 1'b0;
        adr = 3'h0;
        be = 4'hF;
        wdat = 32'h0;
        txq = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_values();
        t_queue_and_lose();
        t_retry_frame();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// *** dv/vpw_bus_model.sv ***
// Purpose: transceiver and bus seen from the transmitter
// Assumes: active level dominates, bus pulled passive
// Notes:   another node is modelled by i_other_active
`timescale 1ns/1ns
`default_nettype none
module vpw_bus_model #(
    parameter int P_DLY = 50
) (
    // clock
    input wire logic i_sys_clk,
    // lines
    input wire logic i_tx,
    input wire logic i_other_active,
    output logic o_rx
);
    // ------------------------------------------------------------
    // loop delay line; wired-or so a dominant node wins arbitration
    // ------------------------------------------------------------
    logic [P_DLY-1:0] dl = '0;
    always @(posedge i_sys_clk) begin
        dl <= {dl[P_DLY-2:0], i_tx};
    end
    assign o_rx = dl[P_DLY-1] | i_other_active;
endmodule
`default_nettype wire

// *** dv/vpw_frame_transmitter_chk.sv ***
// Purpose: port-level checks of the vpw frame transmitter
// Assumes: input polarity not inverted, one clock domain
// Notes:   bound to every transmitter instance
`timescale 1ns/1ns
`default_nettype none
module vpw_frame_transmitter_chk #(
    parameter int P_TV3_CYC = 5000
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // watched ports
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic i_bus_rx_line,
    input wire logic o_bus_tx_line,
    input wire logic o_lost_arb_irq
);
    // ------------------------------------------------------------
    // run length of the output level and whether its echo came back
    // ------------------------------------------------------------
    logic [15:0] run;
    logic seen;
    logic tx_q;
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            run <= 16'hFFFF;
            seen <= 1'b1;
            tx_q <= 1'b0;
        end else begin
            tx_q <= o_bus_tx_line;
            if (o_bus_tx_line != tx_q) begin
                run <= 16'h0000;
                seen <= 1'b0;
            end else begin
                run <= (run == 16'hFFFF) ? run : run + 16'h0001;
                seen <= seen | (i_bus_rx_line == o_bus_tx_line);
            end
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_new_req;
        (i_avs_read || i_avs_write) && !$past(i_avs_read || i_avs_write);
    endsequence
    sequence s_one_wait;
        o_avs_waitrequest ##1 !o_avs_waitrequest;
    endsequence
    chk_one_wait: assert property (s_new_req |-> s_one_wait)
        else $error("bus request not answered after one wait cycle");
    chk_no_idle_wait: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
        else $error("wait request without a request");
    chk_rdata_hold: assert property (!i_avs_read && !$past(i_avs_read) |-> $stable(o_avs_readdata))
        else $error("read data moved without a read");
    chk_echo_first: assert property ($rose(o_bus_tx_line) && run < P_TV3_CYC |-> seen)
        else $error("output toggled before its echo came back");
    chk_passive_min: assert property ($rose(o_bus_tx_line) && run < P_TV3_CYC |-> run >= 1500)
        else $error("passive bit shorter than a short symbol");
    chk_lost_release: assert property ($rose(o_lost_arb_irq) |-> ##[0:1] !o_bus_tx_line)
        else $error("bus not released on lost arbitration");
    chk_level_stands: assert property ($changed(o_bus_tx_line) |=> $stable(o_bus_tx_line) [*8])
        else $error("output level did not stand");
    chk_quiet_reset: assert property (!$past(i_resetn) |-> !o_bus_tx_line && !o_lost_arb_irq)
        else $error("output active right after reset");
endmodule
bind vpw_frame_transmitter vpw_frame_transmitter_chk #(.P_TV3_CYC(P_TV3_CYC)) u_vpw_frame_transmitter_chk (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write),
    .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .i_bus_rx_line(i_bus_rx_line),
    .o_bus_tx_line(o_bus_tx_line),
    .o_lost_arb_irq(o_lost_arb_irq)
);
`default_nettype wire

// *** inc/vpw_pkg.sv ***
// Purpose: shared constants and types of the vpw frame transmitter
// Assumes: 25 MHz system clock
// Notes:   symbol times are kept in microseconds and converted to cycles here
package vpw_pkg;

    // ------------------------------------------------------------
    // clock and symbol timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int IGN_MAX_US = 7;
    localparam int TV1_LO_US = 34;
    localparam int TV1_NOM_US = 64;
    localparam int TV2_NOM_US = 128;
    localparam int TV3_NOM_US = 200;
    localparam int TV4_LO_US = 239;
    localparam int TV4_NOM_US = 280;
    localparam int TV6_NOM_US = 300;
    localparam int SOF_SYNC_MAX_US = 96;
    localparam int LOOP_DELAY_MAX_US = 31;
    localparam int IGN_MAX_CYC = IGN_MAX_US * CYC_PER_US;
    localparam int FILT_LAT_CYC = IGN_MAX_CYC + 1;
    localparam int TV1_LO_CYC = TV1_LO_US * CYC_PER_US;
    localparam int TV1_NOM_CYC = TV1_NOM_US * CYC_PER_US;
    localparam int TV2_NOM_CYC = TV2_NOM_US * CYC_PER_US;
    localparam int TV3_NOM_CYC = TV3_NOM_US * CYC_PER_US;
    localparam int TV4_LO_CYC = TV4_LO_US * CYC_PER_US;
    localparam int TV4_NOM_CYC = TV4_NOM_US * CYC_PER_US;
    localparam int TV6_NOM_CYC = TV6_NOM_US * CYC_PER_US;
    localparam int SOF_SYNC_CYC = SOF_SYNC_MAX_US * CYC_PER_US;
    localparam int LOOP_DELAY_MAX_CYC = LOOP_DELAY_MAX_US * CYC_PER_US;

    // ------------------------------------------------------------
    // register map (word index) and fields
    // ------------------------------------------------------------
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_TX_BYTE_REG = 3'h1;
    localparam logic [2:0] REG_TX_OPCODE_REG = 3'h2;
    localparam logic [2:0] REG_STATUS = 3'h3;
    localparam logic [2:0] REG_RX_BYTE_REG = 3'h4;
    localparam logic [2:0] REG_FILTER = 3'h5;
    localparam int CTRL_DLY_LSB = 0;
    localparam int CTRL_INV_BIT = 5;
    localparam int CTRL_MASK_BIT = 6;
    localparam int STAT_RDY_BIT = 0;
    localparam int STAT_TLA_BIT = 1;
    localparam int STAT_IBD_BIT = 2;
    localparam int STAT_RX_FULL_FLAG_BIT = 3;
    localparam int STAT_BUSY_BIT = 4;
    localparam logic [2:0] OP_MSG = 3'h1;
    localparam logic [2:0] OP_MSG_LAST = 3'h2;
    localparam logic [4:0] DLY_RST = 5'h00;
    localparam logic [31:0] FILTER_RST = 32'h0000_0000;
    localparam logic [7:0] CRC_INIT = 8'hFF;
    localparam logic [7:0] CRC_POLY = 8'h1D;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_ECHO = 2'b01,
        TX_HOLD = 2'b10,
        TX_EOD = 2'b11
    } vpw_tx_state_type;

    typedef struct packed {
        logic lost_arb_irq_mask;
        logic rx_invert;
        logic [4:0] loop_delay_setting;
    } vpw_ctrl_type;

endpackage
